// [design/scm_pkg.sv]
// constants and types for the serial channel clock and mode control block
package scm_pkg;

	// register indices; byte address is four times the index
	localparam logic [15:0] SCM_IDX_CLK_SEL = 16'hFF43;
	localparam logic [15:0] SCM_IDX_MODE = 16'hFF60;
	localparam logic [15:0] SCM_IDX_AUX = 16'hFF61;
	localparam logic [15:0] SCM_IDX_SLV_ADDR = 16'hFF62;
	localparam int SCM_AW = 18;
	localparam logic [17:0] SCM_ADDR_CLK_SEL = {SCM_IDX_CLK_SEL, 2'b00};
	localparam logic [17:0] SCM_ADDR_MODE = {SCM_IDX_MODE, 2'b00};
	localparam logic [17:0] SCM_ADDR_AUX = {SCM_IDX_AUX, 2'b00};
	localparam logic [17:0] SCM_ADDR_SLV_ADDR = {SCM_IDX_SLV_ADDR, 2'b00};

	// reset values
	localparam logic [7:0] SCM_RST_CLK_SEL = 8'h88;
	localparam logic [7:0] SCM_RST_MODE = 8'h00;
	localparam logic [7:0] SCM_RST_SLV_ADDR = 8'h00;

	// mode register fields
	localparam int SCM_MODE_ENABLE = 7;
	localparam int SCM_MODE_MATCH = 6;
	localparam int SCM_MODE_WAKE = 5;
	localparam int SCM_MODE_OP_HI = 4;
	localparam int SCM_MODE_OP_LO = 2;
	localparam int SCM_MODE_SRC_HI = 1;
	localparam int SCM_MODE_SRC_LO = 0;

	// auxiliary register fields
	localparam int SCM_AUX_I2C = 0;
	localparam int SCM_AUX_TX_ONLY = 1;

	// clock select codes and divider geometry
	localparam logic [3:0] SCM_CODE_MIN = 4'h6;
	localparam logic [3:0] SCM_CODE_MAX = 4'hD;
	localparam logic [3:0] SCM_TAP_OFS_STD = 4'h5;
	localparam logic [3:0] SCM_TAP_OFS_I2C = 4'h1;
	localparam int SCM_PRE_W = 13;
	localparam int SCM_TDIV_W = 4;

	// clock source codes in the low two mode bits
	localparam logic [1:0] SCM_SRC_TIMER = 2'h2;
	localparam logic [1:0] SCM_SRC_PRESCALER = 2'h3;

	typedef enum logic [2:0] {
		SCM_OM_3W_MSB = 3'b000,
		SCM_OM_3W_LSB = 3'b001,
		SCM_OM_SBI = 3'b010,
		SCM_OM_2W = 3'b011,
		SCM_OM_I2C = 3'b100
	} scm_opmode_t;

endpackage

// [design/scm_div_if.sv]
// carrier between the control logic and the prescaler
`timescale 1ns/10ps
interface scm_div_if;
	import scm_pkg::*;
	logic ce;
	logic clr;
	logic [SCM_PRE_W-1:0] cnt;
	modport ctl (output ce, output clr, input cnt);
	modport div (input ce, input clr, output cnt);
endinterface

// [design/scm_prescaler.sv]
// free running divider of the main clock
`timescale 1ns/10ps
module scm_prescaler
	import scm_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	scm_div_if.div dv
);

	typedef struct packed {
		logic [SCM_PRE_W-1:0] cnt;
	} scm_pre_state_t;

	scm_pre_state_t s_r;
	scm_pre_state_t s_nxt;

	always_comb begin
		s_nxt = s_r;
		if (dv.clr) begin
			// clean restart so the new tap starts from a known phase
			s_nxt.cnt = '0; // (R21)
		end else begin
			s_nxt.cnt = s_r.cnt + 1'b1; // (R21)
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_r <= '0;
		end else if (dv.ce) begin
			s_r <= s_nxt;
		end
	end

	assign dv.cnt = s_r.cnt;

endmodule

// [design/scm_ctrl.sv]
// serial channel clock select and channel 0 mode control, apb slave
//
// Behaviour
// (R1) single-channel variant: software writes top bits 1000
// (R2) low nibble codes 6..13 give fx/4..fx/512
// (R3) i2c mode: same codes give fx/64..fx/8192
// (R4) divide-by-four only at low main clock
// (R5) upper nibble selects channel 1 clock likewise
// (R6) software stops transfer before changing clock select
// (R7) low mode bits select external, timer, prescaler
// (R8) timer source in i2c divided by sixteen
// (R9) mode bits pick 3-wire order, sbi, 2-wire
// (R10) 2-wire/i2c: clock and data open-drain, other freed
// (R11) wake-up clear: interrupt after every transfer
// (R12) sbi wake-up: interrupt on matched address after release
// (R13) i2c wake-up: interrupt on matched address after command
// (R14) software clears interrupt cause bit before wake-up
// (R15) no shift register write during wake-up
// (R16) match flag compares addresses, zero when disabled
// (R17) match flag is read only
// (R18) enable bit starts and stops channel 0
// (R19) software stops channel before changing mode
// (R20) 3-wire transmit-only frees serial input pin
// (R21) prescaler free runs, restarts on code change; the code restarts on any clock select write while channel 0 is disabled
`timescale 1ns/10ps
module scm_ctrl
	import scm_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [SCM_AW-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic ext_sck_in,
	input wire logic timer_two_output,
	input wire logic [7:0] ch0_shift_register,
	input wire logic transfer_done,
	input wire logic command_detect_flag,
	input wire logic bus_release_detect_flag,
	output logic ch0_serial_clock,
	output logic ch1_serial_clock,
	output logic msb_first,
	output logic sck_open_drain,
	output logic line_a_open_drain,
	output logic line_b_open_drain,
	output logic line_a_port,
	output logic line_b_port,
	output logic xfer_irq
);

	typedef struct packed {
		logic [7:0] clk_sel;
		logic [7:0] mode;
		logic i2c_sel;
		logic tx_only;
		logic [7:0] slv_addr;
		logic match;
		logic irq;
		logic [SCM_TDIV_W-1:0] tdiv;
		logic tm_prev;
		logic ch0_clk;
		logic ch1_clk;
		scm_opmode_t opmode;
		logic msb_first;
		logic sck_od;
		logic la_od;
		logic lb_od;
		logic la_port;
		logic lb_port;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} scm_state_t;

	localparam scm_state_t SCM_STATE_RST = '{
		clk_sel: SCM_RST_CLK_SEL,
		mode: SCM_RST_MODE,
		i2c_sel: 1'b0,
		tx_only: 1'b0,
		slv_addr: SCM_RST_SLV_ADDR,
		match: 1'b0,
		irq: 1'b0,
		tdiv: '0,
		tm_prev: 1'b0,
		ch0_clk: 1'b0,
		ch1_clk: 1'b0,
		opmode: SCM_OM_3W_MSB,
		msb_first: 1'b1,
		sck_od: 1'b0,
		la_od: 1'b0,
		lb_od: 1'b0,
		la_port: 1'b1,
		lb_port: 1'b1,
		pready: 1'b0,
		pslverr: 1'b0,
		prdata: '0
	};

	scm_state_t s_r;
	scm_state_t s_nxt;
	scm_div_if div_bus ();

	// tap of the prescaler for a code; bit 4 flags a legal code
	function automatic logic [4:0] clk_tap(input logic [3:0] code,
		input logic i2c);
		logic [3:0] ofs;
		ofs = i2c ? SCM_TAP_OFS_I2C : SCM_TAP_OFS_STD;
		if (code >= SCM_CODE_MIN && code <= SCM_CODE_MAX) begin
			clk_tap = {1'b1, code - ofs};
		end else begin
			clk_tap = 5'h00;
		end
	endfunction

	// selected prescaler bit; prohibited codes hold the clock low
	function automatic logic tap_level(input logic [4:0] tap,
		input logic [SCM_PRE_W-1:0] cnt);
		tap_level = tap[4] ? cnt[tap[3:0]] : 1'b0;
	endfunction

	function automatic logic addr_mapped(input logic [SCM_AW-1:0] a);
		addr_mapped = (a == SCM_ADDR_CLK_SEL) || (a == SCM_ADDR_MODE) ||
			(a == SCM_ADDR_AUX) || (a == SCM_ADDR_SLV_ADDR);
	endfunction

	logic enable;
	logic i2c_active;
	logic addr_eq;
	logic src_clk;
	logic tm_rise;
	logic wr_cyc;
	logic [7:0] rd_byte;
	logic [2:0] op_bits;

	assign enable = s_r.mode[SCM_MODE_ENABLE];
	assign i2c_active = (s_r.opmode == SCM_OM_I2C);
	assign addr_eq = (s_r.slv_addr == ch0_shift_register);
	assign tm_rise = timer_two_output && !s_r.tm_prev;
	assign op_bits = s_r.mode[SCM_MODE_OP_HI:SCM_MODE_OP_LO];
	assign wr_cyc = psel && penable && s_r.pready && pwrite &&
		!s_r.pslverr;

	always_comb begin
		case (paddr)
			SCM_ADDR_CLK_SEL: rd_byte = s_r.clk_sel;
			// match flag is read from live state, not from storage
			SCM_ADDR_MODE: rd_byte = {s_r.mode[SCM_MODE_ENABLE], s_r.match,
				s_r.mode[SCM_MODE_WAKE:0]}; // (R17)
			SCM_ADDR_AUX: rd_byte = {6'h00, s_r.tx_only, s_r.i2c_sel};
			SCM_ADDR_SLV_ADDR: rd_byte = s_r.slv_addr;
			default: rd_byte = 8'h00;
		endcase
	end

	always_comb begin
		case (s_r.mode[SCM_MODE_SRC_HI:SCM_MODE_SRC_LO])
			SCM_SRC_TIMER: begin
				src_clk = i2c_active ? s_r.tdiv[SCM_TDIV_W-1] :
					timer_two_output; // (R8)
			end
			SCM_SRC_PRESCALER: begin
				src_clk = tap_level(clk_tap(s_r.clk_sel[3:0], i2c_active),
					div_bus.cnt); // (R2) (R3)
			end
			default: src_clk = ext_sck_in; // (R7)
		endcase
	end

	assign div_bus.ce = clk_en;
	// restart only while stopped so a running transfer sees no glitch
	assign div_bus.clr = wr_cyc && (paddr == SCM_ADDR_CLK_SEL) &&
		!enable; // (R21)

	always_comb begin
		s_nxt = s_r;
		s_nxt.pready = 1'b0;
		s_nxt.pslverr = 1'b0;
		s_nxt.irq = 1'b0;

		// zero wait state: answer is ready in the first access cycle
		if (psel && !penable && !s_r.pready) begin
			s_nxt.pready = 1'b1;
			s_nxt.pslverr = !addr_mapped(paddr);
			s_nxt.prdata = {24'h000000, rd_byte};
		end

		if (wr_cyc) begin
			case (paddr)
				SCM_ADDR_CLK_SEL: s_nxt.clk_sel = pwdata[7:0]; // (R5)
				SCM_ADDR_MODE: begin
					s_nxt.mode = pwdata[7:0];
					s_nxt.mode[SCM_MODE_MATCH] = 1'b0; // (R17)
				end
				SCM_ADDR_AUX: begin
					s_nxt.i2c_sel = pwdata[SCM_AUX_I2C];
					s_nxt.tx_only = pwdata[SCM_AUX_TX_ONLY];
				end
				SCM_ADDR_SLV_ADDR: s_nxt.slv_addr = pwdata[7:0];
				default: s_nxt.slv_addr = s_r.slv_addr;
			endcase
		end

		// operating mode decode
		case (op_bits)
			3'b000, 3'b010: s_nxt.opmode = SCM_OM_3W_MSB; // (R9)
			3'b001, 3'b011: s_nxt.opmode = SCM_OM_3W_LSB; // (R9)
			3'b100, 3'b101: s_nxt.opmode = SCM_OM_SBI; // (R9)
			3'b110, 3'b111: begin
				s_nxt.opmode = s_r.i2c_sel ? SCM_OM_I2C : SCM_OM_2W; // (R10)
			end
			default: s_nxt.opmode = SCM_OM_3W_MSB;
		endcase

		// pin roles; bit 2 picks which data line is the bus line
		s_nxt.msb_first = (s_r.opmode != SCM_OM_3W_LSB); // (R9)
		case (s_r.opmode)
			SCM_OM_3W_MSB, SCM_OM_3W_LSB: begin
				s_nxt.sck_od = 1'b0;
				s_nxt.la_od = 1'b0;
				s_nxt.lb_od = 1'b0;
				s_nxt.la_port = s_r.tx_only; // (R20)
				s_nxt.lb_port = 1'b0;
			end
			SCM_OM_SBI: begin
				s_nxt.sck_od = 1'b0;
				s_nxt.la_od = op_bits[0]; // (R9)
				s_nxt.lb_od = !op_bits[0]; // (R9)
				s_nxt.la_port = !op_bits[0];
				s_nxt.lb_port = op_bits[0];
			end
			SCM_OM_2W, SCM_OM_I2C: begin
				s_nxt.sck_od = 1'b1; // (R10)
				s_nxt.la_od = op_bits[0]; // (R10)
				s_nxt.lb_od = !op_bits[0]; // (R10)
				s_nxt.la_port = !op_bits[0]; // (R10)
				s_nxt.lb_port = op_bits[0]; // (R10)
			end
			default: begin
				s_nxt.sck_od = 1'b0;
				s_nxt.la_od = 1'b0;
				s_nxt.lb_od = 1'b0;
				s_nxt.la_port = 1'b1;
				s_nxt.lb_port = 1'b1;
			end
		endcase

		// timer source divider, only counts while the channel runs
		s_nxt.tm_prev = timer_two_output;
		if (!enable) begin
			s_nxt.tdiv = '0; // (R18)
		end else if (tm_rise) begin
			s_nxt.tdiv = s_r.tdiv + 1'b1; // (R8)
		end

		s_nxt.ch0_clk = enable && src_clk; // (R18)
		s_nxt.ch1_clk = tap_level(clk_tap(s_r.clk_sel[7:4], 1'b0),
			div_bus.cnt); // (R5)
		s_nxt.match = enable && addr_eq; // (R16)

		if (enable && transfer_done) begin
			if (!s_r.mode[SCM_MODE_WAKE]) begin
				s_nxt.irq = 1'b1; // (R11)
			end else if (s_r.opmode == SCM_OM_SBI) begin
				s_nxt.irq = addr_eq && command_detect_flag &&
					bus_release_detect_flag; // (R12)
			end else if (s_r.opmode == SCM_OM_I2C) begin
				s_nxt.irq = addr_eq && command_detect_flag; // (R13)
			end
		end

		if (!enable) begin
			// a stopped channel hands every data pin back to the port
			s_nxt.la_port = 1'b1; // (R18)
			s_nxt.lb_port = 1'b1; // (R18)
			s_nxt.la_od = 1'b0;
			s_nxt.lb_od = 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_r <= SCM_STATE_RST;
		end else if (clk_en) begin
			s_r <= s_nxt;
		end
	end

	scm_prescaler u_pre (
		.pclk(pclk),
		.presetn(presetn),
		.dv(div_bus.div)
	);

	assign prdata = s_r.prdata;
	assign pready = s_r.pready;
	assign pslverr = s_r.pslverr;
	assign ch0_serial_clock = s_r.ch0_clk;
	assign ch1_serial_clock = s_r.ch1_clk;
	assign msb_first = s_r.msb_first;
	assign sck_open_drain = s_r.sck_od;
	assign line_a_open_drain = s_r.la_od;
	assign line_b_open_drain = s_r.lb_od;
	assign line_a_port = s_r.la_port;
	assign line_b_port = s_r.lb_port;
	assign xfer_irq = s_r.irq;

endmodule

// [verif/scm_peer.sv]
// serial peer: eight-clock frames on the external clock, timer toggle
`timescale 1ns/10ps
module scm_peer (
	input logic pclk,
	input logic presetn,
	input logic go,
	input logic tmr_on,
	output logic busy,
	output logic sck,
	output logic tmr,
	output logic done
);
	logic [4:0] n;
	assign busy = n != 5'h0;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			n <= 5'h0;
			sck <= 1'h1;
			tmr <= 1'h0;
			done <= 1'h0;
		end else begin
			// clock idles high and stands still between frames
			sck <= busy ? ~sck : 1'h1;
			tmr <= tmr_on & ~tmr;
			done <= n == 5'h1;
			n <= (go && !busy) ? 5'h10 : n - 5'(busy);
		end
	end
endmodule

// [verif/scm_ctrl_props.sv]
// port assertions for the clock and mode control block
`timescale 1ns/10ps
module scm_ctrl_props
	import scm_pkg::*;
(
	input logic pclk,
	input logic presetn,
	input logic psel,
	input logic penable,
	input logic pwrite,
	input logic [SCM_AW-1:0] paddr,
	input logic [31:0] pwdata,
	input logic [31:0] prdata,
	input logic pready,
	input logic ext_sck_in,
	input logic [7:0] ch0_shift_register,
	input logic transfer_done,
	input logic command_detect_flag,
	input logic bus_release_detect_flag,
	input logic ch0_serial_clock,
	input logic xfer_irq
);
	logic [7:0] mode_r, aux_r, sa_r;
	logic acc, en, wk, eq, serial_bus_interface_mode, i2c, ext, sok, iok;
	assign acc = psel && penable && pready;
	assign en = mode_r[SCM_MODE_ENABLE];
	assign wk = en && mode_r[SCM_MODE_WAKE] && transfer_done;
	assign eq = sa_r == ch0_shift_register;
	assign serial_bus_interface_mode = mode_r[4:3] == 2'h2;
	assign i2c = mode_r[4:3] == 2'h3 && aux_r[SCM_AUX_I2C];
	assign ext = en && !mode_r[SCM_MODE_SRC_HI];
	assign iok = command_detect_flag && eq;
	assign sok = iok && bus_release_detect_flag;
	// shadow of the mode, auxiliary and slave address registers, updated only at the access edge
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_r <= 8'h00;
			aux_r <= 8'h00;
			sa_r <= 8'h00;
		end else if (acc && pwrite) begin
			case (paddr)
				SCM_ADDR_MODE: mode_r <= pwdata[7:0];
				SCM_ADDR_AUX: aux_r <= pwdata[7:0];
				SCM_ADDR_SLV_ADDR: sa_r <= pwdata[7:0];
				default: ;
			endcase
		end
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_plain;
		transfer_done && en && !mode_r[SCM_MODE_WAKE];
	endsequence
	sequence s_rd_mode;
		acc && !pwrite && paddr == SCM_ADDR_MODE;
	endsequence
	a_irq_no_wake: assert property (s_plain |=> xfer_irq)
		else $error("no irq after transfer");
	a_sbi_hit: assert property (wk && serial_bus_interface_mode && sok |=> xfer_irq)
		else $error("no irq on sbi address hit");
	a_sbi_miss: assert property (wk && serial_bus_interface_mode && !sok |=> !xfer_irq)
		else $error("irq on sbi address miss");
	a_i2c_hit: assert property (wk && i2c && iok |=> xfer_irq)
		else $error("no irq on i2c address hit");
	a_i2c_miss: assert property (wk && i2c && !iok |=> !xfer_irq)
		else $error("irq on i2c address miss");
	a_match_read: assert property (s_rd_mode |-> prdata[6] == (en && eq))
		else $error("match flag wrong");
	a_clk_off: assert property (!en && !$past(en) |-> !ch0_serial_clock)
		else $error("clock runs while disabled");
	a_ext_follow: assert property (ext && $past(ext)
		|-> ch0_serial_clock == $past(ext_sck_in))
		else $error("external clock not passed");
endmodule
bind scm_ctrl scm_ctrl_props scm_ctrl_props_i (.*);

// [verif/test_scm_ctrl.sv]
// self-checking bench for the clock and mode control block
`timescale 1ns/10ps
module test_scm_ctrl
	import scm_pkg::*;
;
	logic pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr;
	logic [17:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic ext_sck_in, timer_two_output, transfer_done, go, tmr_on, busy, e;
	logic command_detect_flag, bus_release_detect_flag, xfer_irq;
	logic ch0_serial_clock, ch1_serial_clock, msb_first, sck_open_drain;
	logic line_a_open_drain, line_b_open_drain, line_a_port, line_b_port;
	logic [7:0] ch0_shift_register;
	int errors = 0, tests_run = 0, cyc = 0, irqs = 0;
	scm_ctrl scm_ctrl_i (.*);
	scm_peer scm_peer_i (.pclk, .presetn, .go, .tmr_on, .busy,
		.sck(ext_sck_in), .tmr(timer_two_output), .done(transfer_done));
	initial begin
		pclk = 1'h0;
		forever #2 pclk = ~pclk;
	end
	// ceiling leaves margin over the slowest divider measurement
	always @(posedge pclk) begin
		cyc++;
		if (xfer_irq === 1'h1) irqs++;
		if (cyc == 60000) begin
			errors++;
			final_report();
		end
	end
	task automatic final_report();
		if (errors == 0 && tests_run > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] x);
		tests_run++;
		if (g !== x) begin
			errors++;
			$display("wrong value at %0t: %h not %h", $time, g, x);
		end
	endtask
	task automatic apb(input logic w, input logic [17:0] a,
		input logic [7:0] d);
		@(posedge pclk);
		psel <= 1'h1;
		penable <= 1'h0;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge pclk);
		penable <= 1'h1;
		do @(posedge pclk); while (pready !== 1'h1);
		rd = prdata;
		e = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	task automatic set_mode(input logic [7:0] x, input logic [7:0] m);
		apb(1'h1, SCM_ADDR_MODE, 8'h00);
		apb(1'h1, SCM_ADDR_AUX, x);
		apb(1'h1, SCM_ADDR_MODE, m);
		repeat (3) @(posedge pclk);
	endtask
	function automatic logic pk(input logic s);
		return s ? ch1_serial_clock : ch0_serial_clock;
	endfunction
	task automatic meas(input logic s, input int x);
		time t;
		@(posedge pclk iff pk(s) === 1'h0);
		@(posedge pclk iff pk(s) === 1'h1);
		t = $time;
		@(posedge pclk iff pk(s) === 1'h0);
		@(posedge pclk iff pk(s) === 1'h1);
		chk(32'(($time - t) / 4), 32'(x));
	endtask
	task automatic t_regs();
		apb(1'h0, SCM_ADDR_CLK_SEL, 8'h00);
		chk(rd, 32'h88);
		apb(1'h0, SCM_ADDR_MODE, 8'h00);
		chk(rd, 32'h00);
		apb(1'h1, 18'h00010, 8'hFF);
		apb(1'h0, 18'h00010, 8'h00);
		chk(rd, 32'h00);
		chk({31'h0, e}, 32'h1);
	endtask
	task automatic t_match();
		apb(1'h1, SCM_ADDR_SLV_ADDR, 8'h5A);
		ch0_shift_register <= 8'h5A;
		apb(1'h1, SCM_ADDR_MODE, 8'h40);
		apb(1'h0, SCM_ADDR_MODE, 8'h00);
		chk(rd, 32'h00);
		apb(1'h1, SCM_ADDR_MODE, 8'h80);
		apb(1'h0, SCM_ADDR_MODE, 8'h00);
		chk(rd, 32'hC0);
		ch0_shift_register <= 8'hA5;
		apb(1'h0, SCM_ADDR_MODE, 8'h00);
		chk(rd, 32'h80);
	endtask
	task automatic t_modes();
		logic [21:0] tbl [9] = '{{8'h0, 8'h80, 6'h20}, {8'h0, 8'h84, 6'h00},
			{8'h2, 8'h80, 6'h22}, {8'h0, 8'h90, 6'h26}, {8'h0, 8'h94, 6'h29},
			{8'h0, 8'h98, 6'h36}, {8'h0, 8'h9C, 6'h39}, {8'h1, 8'h98, 6'h36},
			{8'h0, 8'h00, 6'h23}};
		foreach (tbl[i]) begin
			set_mode(tbl[i][21:14], tbl[i][13:6]);
			chk({26'h0, msb_first, sck_open_drain, line_a_open_drain,
				line_b_open_drain, line_a_port, line_b_port},
				32'(tbl[i][5:0]));
		end
	endtask
	task automatic t_irq();
		logic [19:0] tbl [9] = '{{8'h0, 8'h80, 4'h1}, {8'h0, 8'h00, 4'h0},
			{8'h0, 8'hB0, 4'hF}, {8'h0, 8'hB0, 4'hA}, {8'h0, 8'hB0, 4'hC},
			{8'h1, 8'hB8, 4'hB}, {8'h1, 8'hB8, 4'h6}, {8'h0, 8'hB8, 4'hE},
			{8'h0, 8'hA0, 4'hE}};
		foreach (tbl[i]) begin
			command_detect_flag <= tbl[i][3];
			bus_release_detect_flag <= tbl[i][2];
			ch0_shift_register <= tbl[i][1] ? 8'h5A : 8'hA5;
			set_mode(tbl[i][19:12], tbl[i][11:4]);
			irqs = 0;
			go <= 1'h1;
			@(posedge pclk);
			go <= 1'h0;
			@(posedge pclk iff busy === 1'h0);
			repeat (3) @(posedge pclk);
			chk(32'(irqs), 32'(tbl[i][0]));
		end
	endtask
	task automatic t_div();
		// code 6 is too fast for this main clock in standard mode, so only the i2c check uses it
		for (int c = 7; c < 14; c++) begin
			apb(1'h1, SCM_ADDR_MODE, 8'h00);
			apb(1'h1, SCM_ADDR_CLK_SEL, 8'(c * 17));
			set_mode(8'h00, 8'h83);
			meas(1'h0, 1 << (c - 4));
			meas(1'h1, 1 << (c - 4));
		end
		set_mode(8'h01, 8'h9B);
		meas(1'h0, 8192);
		apb(1'h1, SCM_ADDR_MODE, 8'h00);
		apb(1'h1, SCM_ADDR_CLK_SEL, 8'h86);
		set_mode(8'h01, 8'h9B);
		meas(1'h0, 64);
		tmr_on <= 1'h1;
		set_mode(8'h01, 8'h9A);
		meas(1'h0, 32);
	endtask
	// low clock enable must freeze the running channel 1 divider
	task automatic t_freeze();
		logic v;
		clk_en <= 1'h0;
		@(posedge pclk);
		v = ch1_serial_clock;
		repeat (20) begin
			@(posedge pclk);
			chk({31'h0, ch1_serial_clock}, {31'h0, v});
		end
		clk_en <= 1'h1;
	endtask
	initial begin
		{presetn, psel, penable, pwrite, go, tmr_on} = 6'h0;
		clk_en = 1'h1;
		paddr = 18'h0;
		pwdata = 32'h0;
		ch0_shift_register = 8'h00;
		command_detect_flag = 1'h0;
		bus_release_detect_flag = 1'h0;
		repeat (3) @(posedge pclk);
		presetn <= 1'h1;
		t_regs();
		t_match();
		t_modes();
		t_irq();
		t_div();
		t_freeze();
		final_report();
	end
endmodule
